// file: common/cbl_pkg.sv
// constants, types and behaviour summary of the cold-boot configuration loader
// What this block does
// - chip-select pin high at start selects master configuration, from the flash unless onchip_source is high
// - chip-select pin low at start selects slave mode, no master activity
// - first master transaction lowers chip select and sends the wake command
// - serial output changes only on falling serial clock edges
// - serial input is ignored while the wake command is sent
// - chip select returns high right after the last command bit
// - at least ten microseconds pass after wake before the next command
// - image selection only in self-load modes and only when the image flag says so
// - power-on or a low config reset pulse restarts a normal boot
// - configuration always starts from the initial image at address zero
// - with the flag clear the initial image loads, select pins untouched
// - with the flag set the two select pins index a vector entry
// - a flash vector entry is a 24-bit image start address
// - for on-chip memory the entry is an on-chip memory address
// - loading restarts from the address read from the vector
// - optionally the deep power-down command follows a finished load
package cbl_pkg;
    localparam int          MCLK_MHZ     = 25;
    localparam int          WAKE_GAP_US  = 10;
    localparam int          WAKE_GAP_CYC = WAKE_GAP_US * MCLK_MHZ;
    localparam int          STRAP_CYC    = 4;
    localparam int          SCK_HALF     = 4;
    localparam logic [7:0]  OP_WAKE      = 8'hab;
    localparam logic [7:0]  OP_SLEEP     = 8'hb9;
    localparam logic [7:0]  OP_READ      = 8'h03;
    localparam logic [23:0] INIT_ADDR    = 24'h000000;
    localparam logic [23:0] VEC_BASE     = 24'h000001;
    localparam logic [23:0] VEC_BYTES    = 24'h000003;
    localparam logic [23:0] IMAGE_BYTES  = 24'h001000;
    localparam int          CB_FLAG_BIT  = 0;

    typedef struct packed {
        logic [7:0]  op;
        logic        has_addr;
        logic [23:0] addr;
        logic [23:0] len;
    } cbl_cmd_t;
endpackage

// file: src/cbl_sync2.sv
// two-stage synchroniser for levels entering a clock domain
`timescale 1ns/1ps
`default_nettype none
module cbl_sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_q;

    always_comb
    begin
        next_meta = d;
        next_q    = meta;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta <= '0;
            q    <= '0;
        end
        else
        begin
            meta <= next_meta;
            q    <= next_q;
        end
    end
endmodule
`default_nettype wire

// file: src/cbl_spi_link.sv
// serial flash shifter running on the link clock
`timescale 1ns/1ps
`default_nettype none
module cbl_spi_link #(
    parameter int SCK_HALF = cbl_pkg::SCK_HALF
) (
    input  wire logic             lclk,
    input  wire logic             lrst,
    input  wire cbl_pkg::cbl_cmd_t cmd,
    input  wire logic             req_tgl,
    input  wire logic             ack_tgl,
    input  wire logic             drive_en,
    input  wire logic             spi_si,
    output logic                  done_tgl,
    output logic                  byte_tgl,
    output logic [7:0]            rx_byte,
    output logic                  spi_sck,
    output logic                  spi_so,
    output logic                  spi_cs_o,
    output logic                  spi_cs_oe
);
    localparam int DW = $clog2(SCK_HALF + 1);

    typedef enum logic [4:0] {
        L_IDLE = 5'b00001,
        L_TX   = 5'b00010,
        L_RX   = 5'b00100,
        L_WACK = 5'b01000,
        L_END  = 5'b10000
    } cbl_lst_t;

    typedef struct packed {
        cbl_lst_t    st;
        logic [31:0] sh;
        logic [5:0]  nbits;
        logic [5:0]  bits;
        logic [23:0] left;
        logic [DW-1:0] div;
        logic        sck;
        logic        so;
        logic        cs;
        logic        oe;
        logic        req_seen;
        logic        done_t;
        logic        byte_t;
        logic [7:0]  rx;
    } cbl_lreg_t;

    cbl_lreg_t  r;
    cbl_lreg_t  next_r;
    logic [3:0] s_in;
    logic       tick;

    cbl_sync2 #(.W(4)) u_sync (
        .clk (lclk),
        .rst (lrst),
        .d   ({req_tgl, ack_tgl, drive_en, spi_si}),
        .q   (s_in)
    );

    always_comb
    begin
        next_r = r;
        tick = (r.div == DW'(SCK_HALF - 1));
        next_r.div = tick ? '0 : r.div + 1'b1;
        next_r.oe = s_in[1];
        case (r.st)
            L_IDLE:
            begin
                if (s_in[3] != r.req_seen)
                begin
                    next_r.req_seen = s_in[3];
                    next_r.sh = {cmd.op, cmd.addr};
                    next_r.nbits = cmd.has_addr ? 6'd32 : 6'd8;
                    next_r.bits = '0;
                    next_r.left = cmd.len;
                    next_r.cs = 1'b0;
                    next_r.so = cmd.op[7];
                    next_r.div = '0;
                    next_r.st = L_TX;
                end
            end
            L_TX:
            begin
                if (tick)
                begin
                    next_r.sck = ~r.sck;
                    if (r.sck)
                    begin
                        // next bit only on the falling edge; input not looked at
                        next_r.sh = {r.sh[30:0], 1'b0};
                        next_r.so = r.sh[30];
                        next_r.bits = r.bits + 6'd1;
                        if (r.bits == r.nbits - 6'd1)
                        begin
                            next_r.bits = '0;
                            next_r.st = (r.left == '0) ? L_END : L_RX;
                        end
                    end
                end
            end
            L_RX:
            begin
                if (tick)
                begin
                    next_r.sck = ~r.sck;
                    if (r.sck)
                    begin
                        next_r.rx = {r.rx[6:0], s_in[0]};
                        next_r.bits = r.bits + 6'd1;
                        if (r.bits == 6'd7)
                        begin
                            next_r.bits = '0;
                            next_r.byte_t = ~r.byte_t;
                            next_r.left = r.left - 24'h000001;
                            next_r.st = L_WACK;
                        end
                    end
                end
            end
            L_WACK:
            begin
                // clock held low until the core has taken the byte
                next_r.div = '0;
                if (s_in[2] == r.byte_t)
                begin
                    next_r.st = (r.left == '0) ? L_END : L_RX;
                end
            end
            L_END:
            begin
                next_r.cs = 1'b1;
                next_r.done_t = ~r.done_t;
                next_r.st = L_IDLE;
            end
            default:
            begin
                next_r.st = L_IDLE;
            end
        endcase
    end

    always_ff @(posedge lclk)
    begin
        if (lrst)
        begin
            r <= '0;
            r.st <= L_IDLE;
            r.cs <= 1'b1;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign done_tgl  = r.done_t;
    assign byte_tgl  = r.byte_t;
    assign rx_byte   = r.rx;
    assign spi_sck   = r.sck;
    assign spi_so    = r.so;
    assign spi_cs_o  = r.cs;
    assign spi_cs_oe = r.oe;

    a_so_on_fall: assert property (@(posedge lclk) disable iff (lrst)
        (!r.cs && $past(!r.cs) && $changed(r.so)) |-> $fell(r.sck))
        else $error("serial output changed away from a falling clock edge");
    a_cs_end_cmd: assert property (@(posedge lclk) disable iff (lrst)
        (r.st == L_TX && tick && r.sck && r.bits == r.nbits - 6'd1 && r.left == '0)
        |=> ##1 (r.cs && r.st == L_IDLE))
        else $error("chip select not released after the last command bit");
    a_rx_only: assert property (@(posedge lclk) disable iff (lrst)
        $changed(r.byte_t) |-> $past(r.st == L_RX) && r.st == L_WACK)
        else $error("byte delivered outside a receive phase");
endmodule
`default_nettype wire

// file: src/cbl_loader.sv
// cold-boot configuration loader top: strap, boot sequence, image selection
`timescale 1ns/1ps
`default_nettype none
module cbl_loader #(
    parameter logic [23:0] IMAGE_BYTES = cbl_pkg::IMAGE_BYTES,
    parameter bit          USE_SLEEP   = 1'b1,
    parameter int          SCK_HALF    = cbl_pkg::SCK_HALF
) (
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire logic        lclk,
    input  wire logic        config_reset_n,
    input  wire logic        onchip_source,
    input  wire logic        boot_image_select_lsb,
    input  wire logic        boot_image_select_msb,
    input  wire logic        spi_cs_i,
    output logic             spi_cs_o,
    output logic             spi_cs_oe,
    output logic             spi_sck,
    output logic             spi_so,
    input  wire logic        spi_si,
    output logic             oc_rd,
    output logic [23:0]      oc_addr,
    input  wire logic [7:0]  oc_data,
    input  wire logic        oc_valid,
    output logic [7:0]       cfg_data,
    output logic             cfg_valid,
    output logic             config_done,
    output logic             slave_mode
);
    typedef enum logic [8:0] {
        C_STRAP = 9'h001,
        C_WAKE  = 9'h002,
        C_GAP   = 9'h004,
        C_HDR   = 9'h008,
        C_VEC   = 9'h010,
        C_LOAD  = 9'h020,
        C_SLEEP = 9'h040,
        C_DONE  = 9'h080,
        C_SLAVE = 9'h100
    } cbl_cst_t;

    typedef struct packed {
        cbl_cst_t          st;
        logic [11:0]       cnt;
        logic              src;
        logic              master;
        logic              slave;
        logic              cb;
        logic              done;
        logic [1:0]        sel;
        logic              sel_taken;
        logic              req_t;
        logic              ack_t;
        logic              done_seen;
        logic              busy;
        logic              oc_wait;
        logic              oc_rd;
        logic [23:0]       f_left;
        logic [23:0]       vec;
        logic [23:0]       oc_addr;
        cbl_pkg::cbl_cmd_t cmd;
        logic [7:0]        cfg_data;
        logic              cfg_valid;
    } cbl_creg_t;

    cbl_creg_t   r;
    cbl_creg_t   nx;
    logic [4:0]  s_pin;
    logic [1:0]  s_lnk;
    logic        lrst;
    logic        link_done;
    logic        link_byte;
    logic [7:0]  rx_byte;
    logic        s_rstn;
    logic        s_cs;
    logic        s_ocsrc;
    logic [1:0]  s_sel;
    logic        s_done;
    logic        s_byte;
    logic        byte_evt;
    logic        fin;
    logic [7:0]  byte_val;
    logic        hdr_cb;
    logic [23:0] vec_now;

    // vector entry address for a select value
    function automatic logic [23:0] vec_addr(input logic [1:0] s);
        return cbl_pkg::VEC_BASE + 24'(s) * cbl_pkg::VEC_BYTES;
    endfunction

    // start a fetch from the current source
    function automatic cbl_creg_t launch(input cbl_creg_t c, input logic [7:0] op,
                                         input logic ha, input logic [23:0] a,
                                         input logic [23:0] n);
        cbl_creg_t o;
        o = c;
        o.busy = 1'b1;
        o.f_left = n;
        if (c.src)
        begin
            o.oc_rd = 1'b1;
            o.oc_addr = a;
            o.oc_wait = 1'b1;
        end
        else
        begin
            o.cmd.op = op;
            o.cmd.has_addr = ha;
            o.cmd.addr = a;
            o.cmd.len = n;
            o.req_t = ~c.req_t;
        end
        return o;
    endfunction

    cbl_sync2 #(.W(5)) u_pin_sync (
        .clk (mclk),
        .rst (srst),
        .d   ({config_reset_n, spi_cs_i, onchip_source,
               boot_image_select_msb, boot_image_select_lsb}),
        .q   (s_pin)
    );

    cbl_sync2 #(.W(2)) u_lnk_sync (
        .clk (mclk),
        .rst (srst),
        .d   ({link_done, link_byte}),
        .q   (s_lnk)
    );

    cbl_sync2 #(.W(1)) u_rst_sync (
        .clk (lclk),
        .rst (1'b0),
        .d   (srst),
        .q   (lrst)
    );

    cbl_spi_link #(.SCK_HALF(SCK_HALF)) u_link (
        .lclk      (lclk),
        .lrst      (lrst),
        .cmd       (r.cmd),
        .req_tgl   (r.req_t),
        .ack_tgl   (r.ack_t),
        .drive_en  (r.master),
        .spi_si    (spi_si),
        .done_tgl  (link_done),
        .byte_tgl  (link_byte),
        .rx_byte   (rx_byte),
        .spi_sck   (spi_sck),
        .spi_so    (spi_so),
        .spi_cs_o  (spi_cs_o),
        .spi_cs_oe (spi_cs_oe)
    );

    assign s_rstn  = s_pin[4];
    assign s_cs    = s_pin[3];
    assign s_ocsrc = s_pin[2];
    assign s_sel   = s_pin[1:0];
    assign s_done  = s_lnk[1];
    assign s_byte  = s_lnk[0];

    always_comb
    begin
        nx = r;
        nx.cfg_valid = 1'b0;
        nx.oc_rd = 1'b0;
        byte_val = r.src ? oc_data : rx_byte;
        byte_evt = r.busy && (r.src ? (r.oc_wait && oc_valid) : (s_byte != r.ack_t));
        fin = r.busy && (r.src ? (byte_evt && r.f_left == 24'h000001)
                               : (s_done != r.done_seen));
        hdr_cb = byte_evt ? byte_val[cbl_pkg::CB_FLAG_BIT] : r.cb;
        vec_now = byte_evt ? {r.vec[15:0], byte_val} : r.vec;
        // fetch engine runs in every state so a restart never strands the link
        if (byte_evt)
        begin
            nx.f_left = r.f_left - 24'h000001;
            if (r.src)
            begin
                nx.oc_wait = 1'b0;
                if (r.f_left != 24'h000001)
                begin
                    nx.oc_rd = 1'b1;
                    nx.oc_addr = r.oc_addr + 24'h000001;
                    nx.oc_wait = 1'b1;
                end
            end
            else
            begin
                nx.ack_t = s_byte;
            end
        end
        if (fin)
        begin
            nx.busy = 1'b0;
            nx.done_seen = s_done;
        end
        case (r.st)
            C_STRAP:
            begin
                if (r.cnt != 12'(cbl_pkg::STRAP_CYC))
                begin
                    nx.cnt = r.cnt + 12'h001;
                end
                else if (!r.busy)
                begin
                    nx.src = s_ocsrc;
                    nx.cnt = '0;
                    if (!s_cs)
                    begin
                        nx.slave = 1'b1;
                        nx.st = C_SLAVE;
                    end
                    else
                    begin
                        nx.master = !s_ocsrc;
                        nx.src = s_ocsrc;
                        if (s_ocsrc)
                        begin
                            nx = launch(nx, cbl_pkg::OP_READ, 1'b1, cbl_pkg::INIT_ADDR,
                                        24'h000001);
                            nx.st = C_HDR;
                        end
                        else
                        begin
                            nx = launch(nx, cbl_pkg::OP_WAKE, 1'b0, '0, '0);
                            nx.st = C_WAKE;
                        end
                    end
                end
            end
            C_WAKE:
            begin
                if (fin)
                begin
                    nx.cnt = '0;
                    nx.st = C_GAP;
                end
            end
            C_GAP:
            begin
                nx.cnt = r.cnt + 12'h001;
                if (r.cnt == 12'(cbl_pkg::WAKE_GAP_CYC - 1))
                begin
                    nx = launch(nx, cbl_pkg::OP_READ, 1'b1, cbl_pkg::INIT_ADDR,
                                24'h000001);
                    nx.st = C_HDR;
                end
            end
            C_HDR:
            begin
                nx.cb = hdr_cb;
                if (fin)
                begin
                    if (hdr_cb)
                    begin
                        nx.sel = s_sel;
                        nx.sel_taken = 1'b1;
                        nx.vec = '0;
                        nx = launch(nx, cbl_pkg::OP_READ, 1'b1, vec_addr(s_sel),
                                    cbl_pkg::VEC_BYTES);
                        nx.st = C_VEC;
                    end
                    else
                    begin
                        nx = launch(nx, cbl_pkg::OP_READ, 1'b1, cbl_pkg::INIT_ADDR,
                                    IMAGE_BYTES);
                        nx.st = C_LOAD;
                    end
                end
            end
            C_VEC:
            begin
                nx.vec = vec_now;
                if (fin)
                begin
                    // entry addresses flash or on-chip memory, whichever is the source
                    nx = launch(nx, cbl_pkg::OP_READ, 1'b1, vec_now,
                                IMAGE_BYTES);
                    nx.st = C_LOAD;
                end
            end
            C_LOAD:
            begin
                if (byte_evt)
                begin
                    nx.cfg_data = byte_val;
                    nx.cfg_valid = 1'b1;
                end
                if (fin)
                begin
                    if (!r.src && USE_SLEEP)
                    begin
                        nx = launch(nx, cbl_pkg::OP_SLEEP, 1'b0, '0, '0);
                        nx.st = C_SLEEP;
                    end
                    else
                    begin
                        nx.done = 1'b1;
                        nx.st = C_DONE;
                    end
                end
            end
            C_SLEEP:
            begin
                if (fin)
                begin
                    nx.done = 1'b1;
                    nx.st = C_DONE;
                end
            end
            C_DONE, C_SLAVE:
            begin
                nx.st = r.st;
            end
            default:
            begin
                nx.st = C_STRAP;
            end
        endcase
        // a low config reset restarts a normal boot at the strap check
        if (!s_rstn)
        begin
            nx.st = C_STRAP;
            nx.cnt = '0;
            nx.master = 1'b0;
            nx.slave = 1'b0;
            nx.done = 1'b0;
            nx.cb = 1'b0;
            nx.sel_taken = 1'b0;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            r <= '0;
            r.st <= C_STRAP;
        end
        else
        begin
            r <= nx;
        end
    end

    assign oc_rd       = r.oc_rd;
    assign oc_addr     = r.oc_addr;
    assign cfg_data    = r.cfg_data;
    assign cfg_valid   = r.cfg_valid;
    assign config_done = r.done;
    assign slave_mode  = r.slave;

    a_strap_master: assert property (@(posedge mclk) disable iff (srst)
        (r.st == C_STRAP && nx.st != C_STRAP && s_cs && s_rstn)
        |=> (!r.slave && r.st != C_SLAVE))
        else $error("high chip-select strap did not start master boot");
    a_strap_slave: assert property (@(posedge mclk) disable iff (srst)
        (r.st == C_STRAP && nx.st != C_STRAP && !s_cs && s_rstn)
        |=> (r.slave && !r.master && r.st == C_SLAVE))
        else $error("low chip-select strap did not give slave mode");
    a_wake_first: assert property (@(posedge mclk) disable iff (srst)
        (r.st == C_STRAP && nx.st == C_WAKE)
        |=> (r.cmd.op == cbl_pkg::OP_WAKE && r.cmd.len == '0 && r.busy))
        else $error("first master command is not a bare wake");
    a_gap_wait: assert property (@(posedge mclk) disable iff (srst)
        (r.st == C_GAP && nx.st == C_HDR) |-> r.cnt == 12'(cbl_pkg::WAKE_GAP_CYC - 1)
        && $past(r.st, cbl_pkg::WAKE_GAP_CYC - 1) == C_GAP)
        else $error("command issued before the wake gap elapsed");
    a_no_select: assert property (@(posedge mclk) disable iff (srst)
        (r.st == C_HDR && nx.st == C_LOAD && s_rstn)
        |=> (!r.sel_taken && (r.src || r.cmd.addr == cbl_pkg::INIT_ADDR)))
        else $error("image without cold-boot flag did not load from its start");
    a_vec_index: assert property (@(posedge mclk) disable iff (srst)
        (r.st == C_HDR && nx.st == C_VEC && !r.src && s_rstn)
        |=> (r.sel_taken && r.cmd.addr == vec_addr(r.sel)
             && r.cmd.len == cbl_pkg::VEC_BYTES))
        else $error("vector read not at the selected entry");
    a_sel_stable: assert property (@(posedge mclk) disable iff (srst)
        (r.sel_taken && $past(r.sel_taken)) |-> $stable(r.sel))
        else $error("image select changed after it was taken");
    a_slave_plain: assert property (@(posedge mclk) disable iff (srst)
        r.slave |-> (!r.sel_taken && !r.master))
        else $error("slave mode used image selection or master drive");
    a_restart_load: assert property (@(posedge mclk) disable iff (srst)
        (r.st == C_VEC && nx.st == C_LOAD && !r.src && s_rstn)
        |=> (r.cmd.addr == $past(vec_now) && r.cmd.len == IMAGE_BYTES))
        else $error("load did not restart from the vector address");
endmodule
`default_nettype wire

// file: sim/cbl_flash_model.sv
// behavioural serial flash facing the loader
`timescale 1ns/1ps
`default_nettype none
module cbl_flash_model (
    input  wire logic cs_n,
    input  wire logic sck,
    input  wire logic so,
    input  wire logic flag,
    output logic      si
);
    logic [7:0]  ops[$];
    logic [23:0] adr[$];
    logic [23:0] a = 0;
    logic [7:0]  d;
    int          n = 0;
    int          bad = 0;
    realtime     t_end = 0;
    initial si = 1'b0;
    function automatic logic [7:0] byte_at(input logic [23:0] x);
        if (x == 0) return {7'h0, flag};
        if (x < 13) return (x % 3 == 0) ? 8'(x / 3 * 32) : 8'h00;
        return x[7:0] ^ 8'h5a;
    endfunction
    // takes command and address bits on rising clock edges
    always @(posedge sck) if (!cs_n)
    begin
        n++;
        if (n <= 32) a = {a[22:0], so};
        if (n == 8) ops.push_back(a[7:0]);
        if (n == 32 && ops[$] == 8'h03) adr.push_back(a);
    end
    // data only after a full read header, noise otherwise
    always @(negedge sck) if (!cs_n)
    begin
        d = byte_at(a + 24'((n - 32) / 8));
        si <= (n >= 32 && ops[$] == 8'h03) ? d[7 - (n - 32) % 8] : ~si;
    end
    always @(posedge cs_n)
    begin
        if (n % 8 != 0) bad++;
        if (ops.size() > 0 && ops[$] == 8'hab) t_end = $realtime;
        n = 0;
        si <= ~si;
    end
    always @(negedge cs_n)
        if (ops.size() > 0 && ops[$] == 8'hab && $realtime - t_end < 10000.0) bad++;
    // judged once the clock update of the same step has settled
    always @(so) if (!cs_n)
    begin
        #1;
        if (sck) bad++;
    end
endmodule
`default_nettype wire

// file: sim/tb.sv
// self-checking bench of the cold-boot loader
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic mclk = 0, lclk = 0, srst = 1, config_reset_n = 1, onchip_source = 0;
    logic strap_lo = 0, flag = 0, oc_valid = 0;
    logic [1:0] sel = 0;
    logic [7:0] oc_data = 0;
    logic spi_cs_o, spi_cs_oe, spi_sck, spi_so, spi_si, oc_rd, cfg_valid, config_done;
    logic slave_mode;
    logic [23:0] oc_addr;
    logic [7:0] cfg_data;
    logic [7:0] got[$];
    int error_cnt = 0, n_tests = 0;
    wire logic cs_pin = strap_lo ? 1'b0 : (spi_cs_oe ? spi_cs_o : 1'b1);
    cbl_flash_model flash (.cs_n(cs_pin), .sck(spi_sck), .so(spi_so), .flag(flag), .si(spi_si));
    cbl_loader #(.IMAGE_BYTES(24'h000010), .SCK_HALF(2)) dut (.mclk, .srst, .lclk,
        .config_reset_n, .onchip_source, .boot_image_select_lsb(sel[0]),
        .boot_image_select_msb(sel[1]), .spi_cs_i(cs_pin), .spi_cs_o, .spi_cs_oe, .spi_sck,
        .spi_so, .spi_si, .oc_rd, .oc_addr, .oc_data, .oc_valid, .cfg_data, .cfg_valid,
        .config_done, .slave_mode);
    initial forever #20 mclk = ~mclk;
    initial
    begin
        #1.7;
        forever #3 lclk = ~lclk;
    end
    // on-chip memory answers one cycle later
    always @(posedge mclk)
    begin
        oc_valid <= #1 (oc_rd === 1'b1);
        oc_data <= #1 flash.byte_at(oc_addr);
        if (cfg_valid === 1'b1) got.push_back(cfg_data);
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic restart;
        @(posedge mclk);
        #1 config_reset_n = 0; // held low for six master clock cycles
        got.delete();
        flash.ops.delete();
        flash.adr.delete();
        repeat (6) @(posedge mclk);
        #1 config_reset_n = 1;
    endtask
    task automatic boot(input logic src, input logic f, input logic [1:0] s);
        logic [23:0] st;
        st = f ? 24'(s + 1) * 24'h20 : 24'h0;
        @(posedge mclk);
        #1 onchip_source = src;
        flag = f;
        sel = s;
        restart;
        repeat (20000) if (config_done !== 1'b1) @(posedge mclk);
        @(negedge mclk);
        check(got.size(), 16);
        foreach (got[i]) check(got[i], flash.byte_at(st + 24'(i)));
        check(flash.ops.size(), src ? 0 : (f ? 5 : 4));
        if (!src)
        begin
            check(flash.ops[0], 8'hab);
            check(flash.adr[0], 0);
            if (f) check(flash.adr[1], 1 + 3 * s);
            check(flash.adr[$], st);
            check(flash.ops[$], 8'hb9);
        end
    endtask
    task automatic slave_boot;
        @(posedge mclk);
        #1 strap_lo = 1;
        restart;
        repeat (300) @(posedge mclk);
        check(slave_mode, 1);
        check(spi_cs_oe, 0);
        check(flash.ops.size(), 0);
    endtask
    task automatic test_done;
        $display("mismatches %0d, checks %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(posedge mclk);
        #1 srst = 0;
        boot(0, 0, 3);
        for (int s = 0; s < 4; s++) boot(0, 1, 2'(s));
        boot(1, 1, 2);
        boot(1, 0, 1);
        slave_boot;
        check(flash.bad, 0);
        test_done;
    end
    initial
    begin
        #2000000;
        error_cnt++;
        test_done;
    end
endmodule
`default_nettype wire
